// ===== tb_timer16_capture_compare.sv
// Self-checking bench of the timer with two capture/compare registers.
`timescale 1ns/10ps
module tb_timer16_capture_compare import tcc_pkg::*;;
	typedef struct {logic [15:0] a; logic [15:0] d; logic [15:0] e;} tcc_row_t;
	logic CORE_CLK = 1'b0;
	logic SRST = 1'b1;
	logic [15:0] ADDR = 16'h0000;
	logic [15:0] WDATA = 16'h0000;
	logic WR = 1'b0;
	logic RD = 1'b0;
	logic [1:0] want = 2'h0;
	logic [1:0] pins;
	logic [15:0] RDATA;
	logic pri_irq;
	logic sec_irq;
	logic [15:0] v;
	logic [15:0] s;
	logic [15:0] p;
	int error_cnt = 0;
	int compares = 0;
	int cyc = 0;
	int n;
	tcc_row_t rows [5] = '{'{16'hff12, 16'h1234, 16'h1234},
		'{16'hff14, 16'habcd, 16'habcd}, '{16'hff10, 16'h5555, 16'h0000},
		'{16'hff1e, 16'hffff, 16'h0000}, '{16'hff12, 16'hffff, 16'hffff}};
	tcc_timer DUT (.CORE_CLK, .SRST, .ADDR, .WDATA, .WR, .RD, .RDATA,
		.PRIMARY_TRIGGER_INPUT(pins[0]), .SECONDARY_TRIGGER_INPUT(pins[1]),
		.PRIMARY_MATCH_INTERRUPT(pri_irq), .SECONDARY_MATCH_INTERRUPT(sec_irq));
	tcc_pin_model u_pins (.clk(CORE_CLK), .want(want), .pins(pins));
	always #12.5 CORE_CLK = ~CORE_CLK;
	always @(posedge CORE_CLK) begin
		cyc++;
		if (cyc == 90000) begin
			error_cnt++;
			report_and_stop();
		end
	end
	task automatic chk(input string what, input logic [15:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [15:0] a, d);
		WR <= 1'b1;
		ADDR <= a;
		WDATA <= d;
		@(posedge CORE_CLK);
		WR <= 1'b0;
		// One idle edge, so that a next write never assigns WR twice at once.
		@(posedge CORE_CLK);
	endtask : wr
	task automatic rd(input logic [15:0] a, output logic [15:0] q);
		RD <= 1'b1;
		ADDR <= a;
		@(posedge CORE_CLK);
		RD <= 1'b0;
		#1 q = RDATA;
		@(posedge CORE_CLK);
	endtask : rd
	// Returns one less than the cycle gap, as it ends one edge late.
	task automatic wait_irq(input logic sec, input int lim, output int k);
		k = 0;
		do begin
			@(posedge CORE_CLK);
			#1 k++;
		end while ((sec ? sec_irq : pri_irq) !== 1'b1 && k < lim);
		if ((sec ? sec_irq : pri_irq) !== 1'b1) begin
			error_cnt++;
			$display("BAD match request expected 1 seen none");
		end
		@(posedge CORE_CLK);
	endtask : wait_irq
	task automatic report_and_stop();
		$display("Checks %0d, mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (4) @(posedge CORE_CLK);
		SRST <= 1'b0;
		@(posedge CORE_CLK);
		for (int i = 0; i < 3; i++) begin
			rd(16'hff10 + 16'(2 * i), v);
			chk("reset value", v, 16'h0000);
		end
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a, v);
			chk("readback", v, rows[i].e);
		end
		wr(16'hff12, 16'h0020);
		wr(16'hff14, 16'h001e);
		wr(16'hff1a, 16'h0005);
		wr(16'hff18, 16'h0000);
		wr(16'hff16, 16'h0004);
		rd(16'hff10, v);
		wait_irq(1'b1, 60, n);
		wait_irq(1'b0, 10, n);
		chk("match gap", 16'(n), 16'h0001);
		wr(16'hff16, 16'h0000);
		rd(16'hff10, v);
		chk("stopped count", v, 16'h0000);
		wr(16'hff12, 16'h0005);
		wr(16'hff16, 16'h000c);
		wait_irq(1'b0, 50, n);
		wait_irq(1'b0, 50, n);
		chk("clear period", 16'(n), 16'h0005);
		wr(16'hff16, 16'h0000);
		wr(16'hff12, 16'h0010);
		wr(16'hff16, 16'h0004);
		RD <= 1'b1;
		ADDR <= 16'hff10;
		@(posedge CORE_CLK);
		#1 v = RDATA;
		@(posedge CORE_CLK);
		RD <= 1'b0;
		#1 s = RDATA;
		chk("count step", s, v + 16'h0001);
		wait_irq(1'b0, 70000, n);
		wait_irq(1'b0, 70000, n);
		chk("wrap period", 16'(n), 16'hffff);
		wr(16'hff16, 16'h0000);
		wr(16'hff18, 16'h0007);
		wr(16'hff1a, 16'h0001);
		wr(16'hff16, 16'h0004);
		want <= 2'h1;
		repeat (20) @(posedge CORE_CLK);
		want <= 2'h0;
		repeat (20) @(posedge CORE_CLK);
		rd(16'hff14, s);
		rd(16'hff12, p);
		chk("capture span", p - s, 16'h0014);
		rd(16'hff10, v);
		rd(16'hff14, v);
		chk("secondary kept", v, s);
		wr(16'hff16, 16'h0000);
		rd(16'hff12, v);
		chk("capture kept", v, p);
		wr(16'hff18, 16'h0000);
		wr(16'hff16, 16'h0006);
		repeat (30) @(posedge CORE_CLK);
		wr(16'hff16, 16'h0046);
		rd(16'hff10, v);
		chk("oneshot clear", 16'(v < 16'h0004), 16'h0001);
		report_and_stop();
	end
endmodule : tb_timer16_capture_compare

// ===== tcc_defs.svh
// Constants of the 16-bit timer with two capture/compare registers.
`ifndef TCC_DEFS_SVH
`define TCC_DEFS_SVH

`define TCC_W 16
`define TCC_RESET_WORD 16'h0000
`define TCC_ALL_ONES 16'hffff

`define TCC_ADDR_COUNT 16'hff10
`define TCC_ADDR_PRIMARY 16'hff12
`define TCC_ADDR_SECONDARY 16'hff14
`define TCC_ADDR_MODE 16'hff16
`define TCC_ADDR_CCC 16'hff18
`define TCC_ADDR_EDGE 16'hff1a

`define TCC_MODE_OVF 0
`define TCC_MODE_ONESHOT 1
`define TCC_MODE_RUN_LO 2
`define TCC_MODE_RUN_HI 3
`define TCC_MODE_OSPT 6

`define TCC_RUN_STOP 2'h0
`define TCC_RUN_FREE 2'h1
`define TCC_RUN_EDGE_CLR 2'h2
`define TCC_RUN_MATCH_CLR 2'h3

`define TCC_CCC_PRI_CAP 0
`define TCC_CCC_SRC 1
`define TCC_CCC_SEC_CAP 2

`define TCC_EDGE_PRI_LO 0
`define TCC_EDGE_PRI_HI 1
`define TCC_EDGE_SEC_LO 2
`define TCC_EDGE_SEC_HI 3
`define TCC_EDGE_DIV_LO 4
`define TCC_EDGE_DIV_HI 5

`define TCC_EDGE_FALL 2'h0
`define TCC_EDGE_RISE 2'h1
`define TCC_EDGE_NONE 2'h2
`define TCC_EDGE_BOTH 2'h3

`define TCC_DIV1 2'h0
`define TCC_DIV2 2'h1
`define TCC_DIV4 2'h2
`define TCC_DIV8 2'h3

`endif

// ===== tcc_pin_edge.sv
// Trigger pin synchroniser, glitch filter and selectable edge detector.
`timescale 1ns/10ps
`include "tcc_defs.svh"
module tcc_pin_edge import tcc_pkg::*; (
	input wire logic clk,
	input wire logic srst,
	input wire logic pin,
	input wire logic [1:0] sel,
	output logic valid_edge,
	output logic opposite_edge
);
	tcc_edge_t s_q;
	tcc_edge_t s_d;

	// A level counts only once the second and third stages agree.
	always_comb begin
		s_d = s_q;
		s_d.s1 = pin;
		s_d.s2 = s_q.s1;
		s_d.s3 = s_q.s2;
		if (s_q.s2 == s_q.s3) begin
			s_d.lvl = s_q.s3;
		end
		s_d.rise = s_d.lvl & ~s_q.lvl;
		s_d.fall = ~s_d.lvl & s_q.lvl;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// Both edges leave no opposite phase, so that an opposite-edge capture never fires.
	always_comb begin
		case (sel)
			`TCC_EDGE_FALL: begin
				valid_edge = s_q.fall;
				opposite_edge = s_q.rise;
			end
			`TCC_EDGE_RISE: begin
				valid_edge = s_q.rise;
				opposite_edge = s_q.fall;
			end
			`TCC_EDGE_BOTH: begin
				valid_edge = s_q.rise | s_q.fall;
				opposite_edge = 1'b0;
			end
			default: begin
				valid_edge = 1'b0;
				opposite_edge = 1'b0;
			end
		endcase
	end
endmodule : tcc_pin_edge

// ===== tcc_pin_model.sv
// Trigger pin driver standing in for the outside world.
`timescale 1ns/10ps
module tcc_pin_model (
	input wire logic clk,
	input wire logic [1:0] want,
	output logic [1:0] pins
);
	// Pins move on the falling edge, away from the sampling edge.
	// The secondary pin is only a trigger here, never a timer output.
	initial pins = 2'h0;
	always @(negedge clk) begin
		pins <= want;
	end
endmodule : tcc_pin_model

// ===== tcc_pkg.sv
// Types shared by the timer and its trigger pin edge detector.
package tcc_pkg;
	`include "tcc_defs.svh"

	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} tcc_bus_t;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
		logic rise;
		logic fall;
	} tcc_edge_t;

	typedef struct packed {
		logic [15:0] count;
		logic [15:0] primary;
		logic [15:0] secondary;
		logic [1:0] run;
		logic oneshot;
		logic ovf;
		logic [2:0] ccc;
		logic [5:0] edge_sel;
		logic [2:0] div;
		logic [15:0] rdata;
		logic irq_pri;
		logic irq_sec;
	} tcc_state_t;
endpackage : tcc_pkg

// ===== tcc_timer.sv
// 16-bit up-counter with two capture/compare registers and trigger pins.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/10ps
`include "tcc_defs.svh"
module tcc_timer import tcc_pkg::*; (
	input wire logic CORE_CLK,
	input wire logic SRST,
	input wire logic [15:0] ADDR,
	input wire logic [15:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [15:0] RDATA,
	input wire logic PRIMARY_TRIGGER_INPUT,
	input wire logic SECONDARY_TRIGGER_INPUT,
	output logic PRIMARY_MATCH_INTERRUPT,
	output logic SECONDARY_MATCH_INTERRUPT
);
	tcc_state_t s_q;
	tcc_state_t s_d;
	tcc_bus_t bus;

	logic pri_valid;
	logic pri_opposite;
	logic sec_valid;
	logic sec_opposite;

	logic run_on;
	logic tick;
	logic [2:0] div_mask;
	logic pri_cap;
	logic sec_cap;
	logic src_opposite;
	logic pri_hit;
	logic sec_hit;
	logic ospt_write;
	logic clear_event;
	logic ovf_set;
	logic wr_mode;
	logic wr_ccc;
	logic wr_edge;
	logic wr_primary;
	logic wr_secondary;

	assign bus.addr = ADDR;
	assign bus.wdata = WDATA;
	assign bus.wr = WR;
	assign bus.rd = RD;

	tcc_pin_edge u_primary_pin (
		.clk(CORE_CLK),
		.srst(SRST),
		.pin(PRIMARY_TRIGGER_INPUT),
		.sel(s_q.edge_sel[`TCC_EDGE_PRI_HI:`TCC_EDGE_PRI_LO]),
		.valid_edge(pri_valid),
		.opposite_edge(pri_opposite)
	);

	tcc_pin_edge u_secondary_pin (
		.clk(CORE_CLK),
		.srst(SRST),
		.pin(SECONDARY_TRIGGER_INPUT),
		.sel(s_q.edge_sel[`TCC_EDGE_SEC_HI:`TCC_EDGE_SEC_LO]),
		.valid_edge(sec_valid),
		.opposite_edge(sec_opposite)
	);

	// The count clock is a one-cycle enable from a small divider.
	always_comb begin
		case (s_q.edge_sel[`TCC_EDGE_DIV_HI:`TCC_EDGE_DIV_LO])
			`TCC_DIV1: begin
				div_mask = 3'h0;
			end
			`TCC_DIV2: begin
				div_mask = 3'h1;
			end
			`TCC_DIV4: begin
				div_mask = 3'h3;
			end
			`TCC_DIV8: begin
				div_mask = 3'h7;
			end
			default: begin
				div_mask = 3'h0;
			end
		endcase
	end

	always_comb begin
		run_on = (s_q.run != `TCC_RUN_STOP);
		tick = run_on && ((s_q.div & div_mask) == 3'h0);
		pri_cap = s_q.ccc[`TCC_CCC_PRI_CAP];
		sec_cap = s_q.ccc[`TCC_CCC_SEC_CAP];
		src_opposite = s_q.ccc[`TCC_CCC_SRC];
		pri_hit = tick && !pri_cap && (s_q.count == s_q.primary);
		sec_hit = tick && !sec_cap && (s_q.count == s_q.secondary);
		wr_mode = bus.wr && (bus.addr == `TCC_ADDR_MODE);
		wr_ccc = bus.wr && (bus.addr == `TCC_ADDR_CCC);
		wr_edge = bus.wr && (bus.addr == `TCC_ADDR_EDGE);
		wr_primary = bus.wr && (bus.addr == `TCC_ADDR_PRIMARY);
		wr_secondary = bus.wr && (bus.addr == `TCC_ADDR_SECONDARY);
		ospt_write = wr_mode && bus.wdata[`TCC_MODE_OSPT];
		clear_event = 1'b0;
		if (s_q.run == `TCC_RUN_EDGE_CLR && pri_valid) begin
			clear_event = 1'b1;
		end
		if (s_q.oneshot && (ospt_write || pri_valid)) begin
			clear_event = 1'b1;
		end
		ovf_set = tick && !clear_event && (s_q.count == `TCC_ALL_ONES);
	end

	always_comb begin
		s_d = s_q;
		s_d.irq_pri = 1'b0;
		s_d.irq_sec = 1'b0;
		s_d.rdata = `TCC_RESET_WORD;

		// Counter: stop wins, then a clearing event, then the tick.
		if (!run_on) begin
			s_d.count = `TCC_RESET_WORD;
			s_d.div = 3'h0;
		end else begin
			s_d.div = s_q.div + 3'h1;
			if (clear_event) begin
				s_d.count = `TCC_RESET_WORD;
			end else if (tick) begin
				if (s_q.run == `TCC_RUN_MATCH_CLR && pri_hit) begin
					s_d.count = `TCC_RESET_WORD;
				end else begin
					s_d.count = s_q.count + 16'h0001;
				end
			end
		end

		// Primary register: capture or compare, never both.
		if (pri_cap) begin
			if (src_opposite) begin
				if (run_on && pri_opposite) begin
					s_d.primary = s_q.count;
				end
				// The secondary edge still requests, without a capture.
				// A stopped timer stays silent, so gate it by the run field.
				if (run_on && sec_valid) begin
					s_d.irq_pri = 1'b1;
				end
			end else if (run_on && sec_valid) begin
				s_d.primary = s_q.count;
				s_d.irq_pri = 1'b1;
			end
		end else if (pri_hit) begin
			s_d.irq_pri = 1'b1;
		end

		// Secondary register looks only at its own mode bit.
		if (sec_cap) begin
			if (run_on && pri_valid) begin
				s_d.secondary = s_q.count;
				s_d.irq_sec = 1'b1;
			end
		end else if (sec_hit) begin
			s_d.irq_sec = 1'b1;
		end

		// Software writes follow the captures, so a primary or secondary write always lands.
		// A captured value otherwise persists until reset or rewrite.
		if (wr_primary) begin
			s_d.primary = bus.wdata;
		end
		if (wr_secondary) begin
			s_d.secondary = bus.wdata;
		end
		if (wr_mode) begin
			s_d.run = bus.wdata[`TCC_MODE_RUN_HI:`TCC_MODE_RUN_LO];
			s_d.oneshot = bus.wdata[`TCC_MODE_ONESHOT];
		end
		if (wr_ccc) begin
			s_d.ccc = bus.wdata[2:0];
		end
		if (wr_edge) begin
			s_d.edge_sel = bus.wdata[5:0];
		end

		// Overflow is cleared by writing zero; a wrap in that cycle wins.
		if (ovf_set) begin
			s_d.ovf = 1'b1;
		end else if (wr_mode) begin
			s_d.ovf = s_q.ovf & bus.wdata[`TCC_MODE_OVF];
		end

		// Reads have no side effect, so no capture hides behind them.
		if (bus.rd) begin
			case (bus.addr)
				`TCC_ADDR_COUNT: begin
					if (run_on) begin
						s_d.rdata = s_q.count;
					end else begin
						s_d.rdata = `TCC_RESET_WORD;
					end
				end
				`TCC_ADDR_PRIMARY: begin
					s_d.rdata = s_q.primary;
				end
				`TCC_ADDR_SECONDARY: begin
					s_d.rdata = s_q.secondary;
				end
				`TCC_ADDR_MODE: begin
					s_d.rdata = {12'h000, s_q.run, s_q.oneshot, s_q.ovf};
				end
				`TCC_ADDR_CCC: begin
					s_d.rdata = {13'h0000, s_q.ccc};
				end
				`TCC_ADDR_EDGE: begin
					s_d.rdata = {10'h000, s_q.edge_sel};
				end
				default: begin
					s_d.rdata = `TCC_RESET_WORD;
				end
			endcase
		end
	end

	// The counter has no write path at all, only the read mux above.
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign RDATA = s_q.rdata;
	assign PRIMARY_MATCH_INTERRUPT = s_q.irq_pri;
	assign SECONDARY_MATCH_INTERRUPT = s_q.irq_sec;
endmodule : tcc_timer

// ===== tcc_timer_props.sv
// Checker of the timer bus and match request outputs.
`timescale 1ns/10ps
module tcc_timer_props import tcc_pkg::*; (
	input wire logic CORE_CLK,
	input wire logic SRST,
	input wire logic [15:0] ADDR,
	input wire logic [15:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic [15:0] RDATA,
	input wire logic PRIMARY_MATCH_INTERRUPT,
	input wire logic SECONDARY_MATCH_INTERRUPT
);
	logic [1:0] run_q;
	logic [1:0] div_q;
	logic rdc;
	logic pi;
	logic si;
	assign rdc = RD && ADDR == 16'hff10;
	assign pi = PRIMARY_MATCH_INTERRUPT;
	assign si = SECONDARY_MATCH_INTERRUPT;
	// Shadows of run field and divider, since only the bus reveals them.
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			run_q <= 2'h0;
			div_q <= 2'h0;
		end else if (WR && ADDR == 16'hff16) begin
			run_q <= WDATA[3:2];
		end else if (WR && ADDR == 16'hff1a) begin
			div_q <= WDATA[5:4];
		end
	end
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (SRST);
	idle_rdata_a: assert property (!RD |=> RDATA == 16'h0000)
		else $error("read data without a read");
	stop_count_a: assert property (rdc && !run_q |=> !RDATA)
		else $error("stopped count not zero");
	count_step_a: assert property (
		rdc && run_q == 2'h1 && !div_q ##1 rdc
		|=> RDATA == $past(RDATA) + 16'h0001)
		else $error("count did not step by one");
	pri_pulse_a: assert property (pi |=> !pi)
		else $error("primary request longer than a cycle");
	sec_pulse_a: assert property (si |=> !si)
		else $error("secondary request longer than a cycle");
	stop_quiet_a: assert property (!run_q [*8] |-> !pi && !si)
		else $error("request while stopped");
	run_start_a: assert property (
		WR && ADDR == 16'hff16 && WDATA[3:2] == 2'h1 && !run_q && !div_q
		##2 rdc |=> RDATA <= 16'h0001)
		else $error("count did not start from zero");
	rst_quiet_a: assert property ($fell(SRST) |-> !pi && !si)
		else $error("request right after reset");
	cover property (pi);
	cover property (si);
	cover property (rdc ##1 rdc);
endmodule : tcc_timer_props

bind tcc_timer tcc_timer_props u_props (.CORE_CLK, .SRST, .ADDR, .WDATA,
	.WR, .RD, .RDATA, .PRIMARY_MATCH_INTERRUPT, .SECONDARY_MATCH_INTERRUPT);
